// File: design/ldoc_map.vh
// constants for the display output control block
// assumes inclusion by design files only; definitions, no logic
`ifndef LDOC_MAP_VH
`define LDOC_MAP_VH
`define LDOC_ROWS          64
`define LDOC_MUX_W         7
`define LDOC_MUX_FULL      7'h22
`define LDOC_MUX_HALF      7'h21
`define LDOC_MUX_QUARTER   7'h10
`define LDOC_CLK_MHZ       250
`define LDOC_FPS_LOW       80
`define LDOC_FPS_HIGH      100
`define LDOC_SLEEP_EXIT_NS   1000
`define LDOC_SUPPLY_UP_NS    2000
`define LDOC_ST_SLEEP      3'h0
`define LDOC_ST_WAKE       3'h1
`define LDOC_ST_SUPPLY     3'h2
`define LDOC_ST_ACTIVE     3'h3
`endif

// File: design/ldoc_frame_timer.v
// frame tick generator: divides the system clock to the frame period
// assumes clk_sys at the rate in the map header and a synchronous reset
`timescale 1ns/100ps
module ldoc_frame_timer #(
   parameter CNT_W = 24
) (
   input  wire             clk_sys,
   input  wire             rst_n,
   input  wire             run,
   input  wire [CNT_W-1:0] period,
   output reg              tick
);
   reg [CNT_W-1:0] count;

   always @(posedge clk_sys) begin
      if (!rst_n || !run) begin
         count <= {CNT_W{1'b0}};
         tick  <= 1'b0;
      end else if (count >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
         count <= {CNT_W{1'b0}};
         tick  <= 1'b1;
      end else begin
         count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         tick  <= 1'b0;
      end
   end
endmodule // ldoc_frame_timer

// File: design/ldoc_output_ctrl.v
// display output control: frame rate, driver enable and sleep ordering,
// all-pixels-on and inversion on the column drivers
// assumes control bits come straight from a command decoder, synchronous
`timescale 1ns/100ps
`include "ldoc_map.vh"
// Notes on behaviour
// [R1] frame rate 80 or 100 by one bit
// [R2] halve at mux 33, quarter at 16
// [R3] enable puts all drivers idle or active
// [R4] idle drivers tied together, no DC
// [R5] enable cleared: drivers idle, enter sleep
// [R6] enable set: wake, restore supply, then drive
// [R7] enable overrides all-on and inversion
// [R8] all-on forces every column ON
// [R9] all-on ignored when disabled, RAM untouched
// [R10] inversion complements RAM pixel on columns
// [R11] 64 row drivers, output x drives row x
// [R12] row-to-pixel mapping fixed under all settings
// [R13] partial mode mux is first..last rows inclusive
// [R14] row indices gate activity, not RAM mapping
// [R15] all-on beats inversion
module ldoc_output_ctrl #(
   parameter COLS     = 132,
   parameter ROWS     = `LDOC_ROWS,
   parameter CNT_W    = 24,
   parameter WAKE_NS  = `LDOC_SLEEP_EXIT_NS,
   parameter SUPPLY_NS = `LDOC_SUPPLY_UP_NS
) (
   input  wire            clk_sys,
   input  wire            rst_n,
   input  wire            display_enable,
   input  wire            all_pixels_on,
   input  wire            invert_pixels,
   input  wire            frame_rate_high,
   input  wire            partial_enable,
   input  wire [6:0]      row_end_index,
   input  wire [6:0]      partial_first_row,
   input  wire [6:0]      partial_last_row,
   input  wire [COLS-1:0] ramPixels,
   input  wire [ROWS-1:0] rowScan,
   output reg  [COLS-1:0] colDrive,
   output reg  [ROWS-1:0] rowDrive,
   output reg             driversTied,
   output reg             sleepMode,
   output reg             supplyOn,
   output reg             enableFlag,
   output reg  [6:0]      muxRate,
   output reg  [1:0]      rateDiv,
   output reg             frameTick
);
   // settle waits round up, so a faster clock never cuts them short
   localparam integer WAKE_CYC =
      (WAKE_NS * `LDOC_CLK_MHZ + 999) / 1000;
   localparam integer SUPPLY_CYC =
      (SUPPLY_NS * `LDOC_CLK_MHZ + 999) / 1000;
   localparam integer WAKE_END   = WAKE_CYC - 1;
   localparam integer SUPPLY_END = SUPPLY_CYC - 1;
   localparam [15:0]  WAKE_LAST   = WAKE_END[15:0];
   localparam [15:0]  SUPPLY_LAST = SUPPLY_END[15:0];
   localparam integer PERIOD_LOW_I =
      (`LDOC_CLK_MHZ * 1000000) / `LDOC_FPS_LOW;
   localparam integer PERIOD_HIGH_I =
      (`LDOC_CLK_MHZ * 1000000) / `LDOC_FPS_HIGH;
   // quarter rate shifts the period by two; CNT_W must still hold it
   localparam [CNT_W-1:0] PERIOD_LOW  = PERIOD_LOW_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PERIOD_HIGH = PERIOD_HIGH_I[CNT_W-1:0];

   reg  [2:0]       state;
   reg  [15:0]      waitCount;
   reg  [6:0]       next_muxRate;
   reg  [1:0]       next_rateDiv;
   reg  [CNT_W-1:0] period;
   reg  [ROWS-1:0]  rowGate;
   reg  [COLS-1:0] next_colDrive;
   wire             active;
   wire             tick;
   wire             partialOk;
   integer          i;

   assign active = (state == `LDOC_ST_ACTIVE);

   // an inverted window falls back to the row end, for mux and gating
   assign partialOk = partial_enable
                      && (partial_last_row >= partial_first_row);

   // effective mux rate; partial window counts inclusive rows
   always @* begin
      if (partialOk)
         next_muxRate = partial_last_row - partial_first_row
                        + 7'h01; // see [R13]
      else
         next_muxRate = row_end_index + 7'h01;
      // thresholds inclusive: 33 rows halve, 16 rows quarter
      if (next_muxRate <= `LDOC_MUX_QUARTER)
         next_rateDiv = 2'h2; // see [R2]
      else if (next_muxRate <= `LDOC_MUX_HALF)
         next_rateDiv = 2'h1; // see [R2]
      else
         next_rateDiv = 2'h0;
   end

   // the divide lengthens the period; fps select is one bit
   always @* begin
      period = frame_rate_high ? PERIOD_HIGH : PERIOD_LOW; // see [R1]
      period = period << next_rateDiv; // see [R2]
   end

   // row gating uses indices only; row x always drives pixel row x
   always @* begin
      for (i = 0; i < ROWS; i = i + 1) begin
         if (partialOk)
            rowGate[i] = (i >= partial_first_row)
                         && (i <= partial_last_row); // see [R14]
         else
            rowGate[i] = (i <= row_end_index); // see [R14]
      end
   end

   // priority: enable, then all-on, then inversion
   // display RAM is only read here, never written back
   always @* begin
      if (!active)
         next_colDrive = {COLS{1'b0}}; // see [R7] [R9]
      else if (all_pixels_on)
         next_colDrive = {COLS{1'b1}}; // see [R8] [R15]
      else if (invert_pixels)
         next_colDrive = ~ramPixels; // see [R10]
      else
         next_colDrive = ramPixels;
   end

   ldoc_frame_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (active),
      .period  (period),
      .tick    (tick)
   );

   // sleep exit ordering: wake, then supply, then drivers
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state      <= `LDOC_ST_SLEEP;
         waitCount  <= 16'h0000;
         enableFlag <= 1'b0;
         sleepMode  <= 1'b1;
         supplyOn   <= 1'b0;
      end else begin
         enableFlag <= display_enable; // see [R6]
         // a drop of enable wins over any wait in progress
         if (!display_enable) begin
            state     <= `LDOC_ST_SLEEP; // see [R5]
            sleepMode <= 1'b1;
            supplyOn  <= 1'b0;
            waitCount <= 16'h0000;
         end else begin
            case (state)
               `LDOC_ST_SLEEP: begin
                  state     <= `LDOC_ST_WAKE; // see [R6]
                  sleepMode <= 1'b0;
                  supplyOn  <= 1'b0;
                  waitCount <= 16'h0000;
               end
               `LDOC_ST_WAKE: begin
                  if (waitCount >= WAKE_LAST) begin
                     state     <= `LDOC_ST_SUPPLY; // see [R6]
                     supplyOn  <= 1'b1;
                     waitCount <= 16'h0000;
                  end else
                     waitCount <= waitCount + 16'h0001;
               end
               `LDOC_ST_SUPPLY: begin
                  if (waitCount >= SUPPLY_LAST) begin
                     state     <= `LDOC_ST_ACTIVE; // see [R6]
                     waitCount <= 16'h0000;
                  end else
                     waitCount <= waitCount + 16'h0001;
               end
               // drivers stay on until enable drops; supply is held
               `LDOC_ST_ACTIVE: begin
                  state    <= `LDOC_ST_ACTIVE;
                  supplyOn <= 1'b1;
               end
               // an unused code falls back to a clean sleep
               default: begin
                  state     <= `LDOC_ST_SLEEP;
                  sleepMode <= 1'b1;
                  supplyOn  <= 1'b0;
                  waitCount <= 16'h0000;
               end
            endcase
         end
      end
   end

   // registered driver outputs
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         colDrive    <= {COLS{1'b0}};
         rowDrive    <= {ROWS{1'b0}};
         driversTied <= 1'b1;
         muxRate     <= 7'h00;
         rateDiv     <= 2'h0;
         frameTick   <= 1'b0;
      end else begin
         // idle columns sit at zero while the tie switch holds the panel
         colDrive    <= next_colDrive;
         // all drivers move together between idle and active
         rowDrive    <= active ? (rowScan & rowGate)
                               : {ROWS{1'b0}}; // see [R3] [R11] [R12]
         driversTied <= ~active; // see [R4]
         // mux and divide are reported for the bias and timing logic
         muxRate     <= next_muxRate;
         rateDiv     <= next_rateDiv;
         frameTick   <= tick;
      end
   end
endmodule // ldoc_output_ctrl

// File: tb/ldoc_monitor.sv
// checker for the display output control ports
// assumes bind onto ldoc_output_ctrl, one clk_sys domain
`timescale 1ns/100ps
module ldoc_monitor (
   input wire         clk_sys,
   input wire         rst_n,
   input wire         display_enable,
   input wire         all_pixels_on,
   input wire         invert_pixels,
   input wire [131:0] ramPixels,
   input wire [131:0] colDrive,
   input wire [63:0]  rowDrive,
   input wire         driversTied,
   input wire         sleepMode,
   input wire         supplyOn,
   input wire         enableFlag,
   input wire [6:0]   muxRate,
   input wire [1:0]   rateDiv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_SLEEP: assert property (!display_enable |=> sleepMode)
      else $error("sleep not entered");
   // one spare edge allowed for the driver state to follow
   AST_IDLE: assert property (!display_enable [*2] |=> driversTied)
      else $error("drivers not idle");
   AST_TIED: assert property (driversTied |-> colDrive == 132'h0
      && rowDrive == 64'h0) else $error("idle drivers not tied");
   AST_WAKE: assert property ($rose(display_enable) |=>
      enableFlag && !sleepMode) else $error("wake not started");
   // enable may drop on the very edge the drivers turn on
   AST_ORDER: assert property ($fell(driversTied) |->
      $past(supplyOn) && !$past(sleepMode))
      else $error("drivers on too early");
   AST_SUPPLY: assert property ($rose(supplyOn) |->
      !sleepMode && driversTied) else $error("supply order wrong");
   AST_ALLON: assert property (!driversTied && $past(all_pixels_on)
      |-> &colDrive) else $error("all-on not forced");
   AST_INV: assert property (!driversTied && !$past(all_pixels_on)
      && $past(invert_pixels) |-> colDrive == ~$past(ramPixels))
      else $error("inversion wrong");
   AST_QUART: assert property (muxRate inside {[1:16]}
      && $stable(muxRate) |-> rateDiv == 2'h2) else $error("no quarter");
   AST_FULL: assert property (muxRate > 7'h21 && $stable(muxRate)
      |-> rateDiv == 2'h0) else $error("full rate divided");
   cover property ($fell(driversTied));
   cover property (!driversTied && all_pixels_on && invert_pixels);
   cover property (rateDiv == 2'h1);
endmodule // ldoc_monitor
bind ldoc_output_ctrl ldoc_monitor i_mon (.clk_sys, .rst_n,
   .display_enable, .all_pixels_on, .invert_pixels, .ramPixels, .colDrive,
   .rowDrive, .driversTied, .sleepMode, .supplyOn, .enableFlag, .muxRate,
   .rateDiv);

// File: tb/ldoc_host.sv
// host model: latches control writes and presents them as level flags
// assumes writes set up on the falling edge, flags change on falling edge
`timescale 1ns/100ps
module ldoc_host (
   input wire       clk_sys,
   input wire       wr,
   input wire [4:0] cmd,
   output reg [4:0] ctl
);
   reg [4:0] hold = 5'h00;
   initial ctl = 5'h00;
   always @(posedge clk_sys) if (wr) hold <= cmd;
   // falling edge keeps flag changes away from the block's sampling edge
   always @(negedge clk_sys) ctl <= hold;
endmodule // ldoc_host

// File: tb/tb_lcd_display_output_control.sv
// self-checking bench for the display output control block
// assumes host model in tb/, clk_sys at 250 MHz, short wake times
`timescale 1ns/100ps
module tb_lcd_display_output_control;
   logic         clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0;
   logic [4:0]   cmd = 5'h00, ctl;
   logic [6:0]   rowEnd = 7'h3f, mx, e;
   logic [131:0] ram = 132'h0, col;
   logic [63:0]  scan = 64'h0, row;
   logic [1:0]   rd;
   logic         tied, slp, sup, ef, ft;
   logic [1:0]   x;
   logic [31:0]  s = 32'h4a7e;
   logic [6:0]   ends [5] = '{7'h3f, 7'h21, 7'h20, 7'h10, 7'h0f};
   logic [195:0] q[$];
   int n_fail = 0, tests_run = 0, k, m;
   int ticks = 0;
   always #2 clk_sys = ~clk_sys;
   ldoc_host i_host (.clk_sys(clk_sys), .wr(wr), .cmd(cmd), .ctl(ctl));
   ldoc_output_ctrl #(.WAKE_NS(8), .SUPPLY_NS(8)) i_dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .display_enable(ctl[0]), .all_pixels_on(ctl[1]),
      .invert_pixels(ctl[2]), .frame_rate_high(ctl[3]),
      .partial_enable(ctl[4]), .row_end_index(rowEnd),
      .partial_first_row(7'h02), .partial_last_row(7'h05), .ramPixels(ram),
      .rowScan(scan), .colDrive(col), .rowDrive(row), .driversTied(tied),
      .sleepMode(slp), .supplyOn(sup), .enableFlag(ef), .muxRate(mx),
      .rateDiv(rd), .frameTick(ft));
   function automatic logic [31:0] nx();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // row window as the rules define it, from the bench's own settings
   function automatic logic [63:0] gate();
      for (int i = 0; i < 64; i++)
         gate[i] = ctl[4] ? (i >= 2 && i <= 5) : (i <= rowEnd);
   endfunction
   task automatic chk(logic [195:0] got, logic [195:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic host(logic [4:0] c);
      @(negedge clk_sys);
      cmd = c;
      wr = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
   // expectation noted at drive time, checked after the registering edge
   task automatic frame(int n);
      logic [159:0] r;
      for (int i = 0; i < n; i++) begin
         r = {nx(), nx(), nx(), nx(), nx()};
         @(negedge clk_sys);
         ram = r[131:0];
         scan = r[159:96];
         q.push_back({scan & gate(),
                      ctl[1] ? {132{1'b1}} : ctl[2] ? ~ram : ram});
      end
   endtask
   always @(posedge clk_sys) begin
      #1;
      if (q.size() > 0)
         chk({row, col}, q.pop_front());
   end
   // a frame period is millions of cycles, so no tick is due in this run
   always @(negedge clk_sys) if (ft === 1'b1) ticks++;
   initial begin
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      chk({slp, tied, sup}, 196'h6);
      host(5'h01);
      for (k = 0; k < 40 && tied !== 1'b0; k++) @(negedge clk_sys);
      if (k == 40) begin
         n_fail++;
         wrap_up();
      end
      chk({slp, sup}, 196'h1);
      chk(ef, 196'h1);
      $display("wake done");
      for (m = 0; m < 4; m++) begin
         host({1'b0, s[0], m[1:0], 1'b1});
         frame(8);
      end
      $display("column modes done");
      for (m = 0; m < 5; m++) begin
         // let the last queued frame be taken before the window moves
         @(negedge clk_sys);
         rowEnd = ends[m];
         frame(4);
         e = ends[m] + 7'h01;
         x = e <= 7'h10 ? 2'h2 : e <= 7'h21 ? 2'h1 : 2'h0;
         chk({mx, rd}, {e, x});
      end
      host(5'h11);
      chk({mx, rd}, {7'h04, 2'h2});
      frame(8);
      $display("mux rates done");
      host(5'h02);
      chk({slp, tied, col}, {2'h3, 132'h0});
      chk(ef, 196'h0);
      chk(ticks, 196'h0);
      $display("disable done");
      wrap_up();
   end
endmodule // tb_lcd_display_output_control
